// >>> design/dcc_channel.sv
// Digital channel counter, timer and switch output with APB registers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module dcc_channel #(
   parameter int unsigned CHAN_NUM = 29,
   parameter bit SWITCH_POD = 1'b0,
   parameter int unsigned GATE_BASE_CYC = dcc_pkg::GATE_10MS_CYC,
   parameter int unsigned COUNT_W = dcc_pkg::COUNT_W_DEF
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire dcc_pkg::apb_req_t apb_req,
   output dcc_pkg::apb_rsp_t apb_rsp,
   input wire logic chan_in,
   output logic chan_out,
   output logic chan_oe
);
   import dcc_pkg::*;

   // Refuse parameter values the logic cannot serve
   if (CHAN_NUM < 1 || CHAN_NUM > CHAN_MAX || COUNT_W < 1 || COUNT_W > 32
       || GATE_BASE_CYC < 1 || GATE_BASE_CYC > 4_000_000) begin : g_bad
      $error("dcc_channel: parameter out of range");
   end

   // Digital I/O allowed on this channel
   localparam bit IO_OK = !SWITCH_POD ||
      (CHAN_NUM >= CHAN_IO_FIRST && CHAN_NUM <= CHAN_IO_LAST);

   // Measurement sequencer states
   typedef enum logic [1:0] {
      M_IDLE,
      M_WAIT,
      M_RUN
   } meas_state_t;

   // Mode code accepted by this pod and channel
   function automatic logic mode_ok(input logic [11:0] m);
      logic ok;
      ok = 1'b0;
      if (m == MODE_SKIP) begin
         ok = 1'b1;
      end else if (!IO_OK) begin
         ok = 1'b0;
      end else if (m == MODE_STATUS) begin
         ok = 1'b1;
      end else if (m[11:4] == GRP_CAPT) begin
         ok = (m[3:0] <= 4'h2);
      end else if (m[11:4] == GRP_SWITCH) begin
         ok = (m[3:0] <= 4'h1);
      end else if (!SWITCH_POD) begin
         // Totalize, increment and timing exist only on the digital pod
         unique case (m[11:4])
            GRP_TOTAL, GRP_INCR: ok = (m[3:0] <= 4'h2);
            GRP_FREQ, GRP_PERIOD: ok = (m[3:0] <= 4'h3);
            GRP_ONESHOT: ok = (m[3:0] <= 4'h1);
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // Edge selected by last digit: 0 falling, 1 rising, 2 both
   function automatic logic edge_hit(input logic [3:0] sel, input logic r, input logic f);
      logic hit;
      unique case (sel)
         4'h0: hit = f;
         4'h1: hit = r;
         4'h2: hit = r | f;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Synchronised input and its edges
   logic lvl;
   logic rise;
   logic fall;

   dcc_in_sync u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .chan_in(chan_in),
      .level(lvl),
      .rise(rise),
      .fall(fall)
   );

   // State registers
   logic [11:0] mode_q; // Channel mode code
   logic out_q; // Switch output level
   logic oe_q; // Switch output driven
   logic [COUNT_W-1:0] count_q; // Event counter
   logic run_q; // Counting running (totalize or increment)
   logic armed_q; // Capture armed
   logic [31:0] result_q; // Last result
   logic [1:0] err_q; // Error code of last result
   logic valid_q; // Result waiting to be read
   logic [31:0] prdata_q; // Read data snapshot
   meas_state_t meas_q; // Timing sequencer
   logic [31:0] cyc_q; // Cycle timer or gate countdown
   logic [31:0] n_q; // Period or frequency edge count
   logic done_q; // Timing result ready pulse
   logic [31:0] done_val_q; // Timing result value

   // APB decode
   logic setup;
   logic access;
   logic mapped;
   logic mode_wr;
   logic cmd_wr;
   logic trig;
   logic zero_cmd;
   logic halt_cmd;
   logic arm_cmd;
   logic result_rd;
   logic [11:0] new_mode;
   logic [7:0] grp;
   logic [3:0] sub;
   logic ok;
   logic hit;

   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign mapped = (apb_req.paddr == MODE_OFS) || (apb_req.paddr == CMD_OFS)
      || (apb_req.paddr == RESULT_OFS) || (apb_req.paddr == STATUS_OFS);
   assign mode_wr = access & apb_req.pwrite & (apb_req.paddr == MODE_OFS);
   assign cmd_wr = access & apb_req.pwrite & (apb_req.paddr == CMD_OFS);
   assign trig = cmd_wr & apb_req.pwdata[CMD_TRIG_BIT];
   assign zero_cmd = cmd_wr & apb_req.pwdata[CMD_ZERO_BIT];
   assign halt_cmd = cmd_wr & apb_req.pwdata[CMD_HALT_BIT];
   assign arm_cmd = cmd_wr & apb_req.pwdata[CMD_ARM_BIT];
   assign result_rd = access & ~apb_req.pwrite & (apb_req.paddr == RESULT_OFS);
   assign new_mode = apb_req.pwdata[11:0];
   assign grp = mode_q[11:4];
   assign sub = mode_q[3:0];
   assign ok = mode_ok(mode_q);
   assign hit = edge_hit(sub, rise, fall);

   // Zero-wait slave; unmapped address answers with an error
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = access & ~mapped;
   assign apb_rsp.prdata = prdata_q;

   // Read data captured in the setup cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !apb_req.pwrite) begin
         unique case (apb_req.paddr)
            MODE_OFS: prdata_q <= {20'h0_0000, mode_q};
            RESULT_OFS: prdata_q <= result_q;
            STATUS_OFS: begin
               prdata_q <= 32'h0000_0000;
               prdata_q[ST_VALID_BIT] <= valid_q;
               prdata_q[ST_ERR_LSB +: 2] <= err_q;
               prdata_q[ST_LEVEL_BIT] <= lvl;
               prdata_q[ST_RUN_BIT] <= run_q;
               prdata_q[ST_ARMED_BIT] <= armed_q;
               prdata_q[ST_OUT_BIT] <= out_q;
               prdata_q[ST_OE_BIT] <= oe_q;
               prdata_q[ST_BUSY_BIT] <= (meas_q != M_IDLE);
            end
            default: prdata_q <= 32'h0000_0000; // Command and unmapped read zero
         endcase
      end
   end

   // Channel mode register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mode_q <= MODE_RST;
      end else if (mode_wr) begin
         mode_q <= new_mode; // Stored as given; checked at measure time
      end
   end

   // Switch output follows the mode write at once
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         out_q <= OUT_RST;
         oe_q <= 1'b0;
      end else if (mode_wr) begin
         if (mode_ok(new_mode) && new_mode[11:4] == GRP_SWITCH) begin
            out_q <= (new_mode[3:0] == 4'h0);
            oe_q <= 1'b1;
         end else begin
            oe_q <= 1'b0; // Released when channel leaves switch mode
         end
      end
   end

   assign chan_out = out_q;
   assign chan_oe = oe_q;

   // Event counter, run and capture arm
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count_q <= '0;
         run_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (zero_cmd) begin
         count_q <= '0;
         run_q <= 1'b0; // Waits for next trigger
      end else if (mode_wr) begin
         count_q <= '0;
         armed_q <= 1'b0; // Mode write never arms capture
         // Totalize run carries into totalize or increment
         if ((new_mode[11:4] == GRP_TOTAL || new_mode[11:4] == GRP_INCR)
             && mode_ok(new_mode)) begin
            run_q <= run_q & (grp == GRP_TOTAL) & ok;
         end else begin
            run_q <= 1'b0;
         end
      end else if (halt_cmd) begin
         run_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (trig && ok && grp == GRP_TOTAL) begin
         run_q <= 1'b1; // Keeps total, no clear
         if (run_q && hit) begin
            count_q <= count_q + COUNT_W'(1);
         end
      end else if (trig && ok && grp == GRP_INCR) begin
         run_q <= 1'b1;
         count_q <= hit ? COUNT_W'(1) : '0; // Fresh count
      end else if (arm_cmd && ok && grp == GRP_CAPT) begin
         armed_q <= 1'b1;
         count_q <= '0;
      end else if (hit && ok && ((run_q && (grp == GRP_TOTAL || grp == GRP_INCR))
                   || (armed_q && grp == GRP_CAPT))) begin
         count_q <= count_q + COUNT_W'(1); // Wraps silently
      end
   end

   // Gate length for frequency mode
   function automatic logic [31:0] gate_cycles(input logic [3:0] s);
      logic [31:0] g;
      g = 32'(GATE_BASE_CYC);
      unique case (s)
         4'h0: g = 32'(GATE_BASE_CYC);
         4'h1: g = 32'(GATE_BASE_CYC) * 32'd10;
         4'h2: g = 32'(GATE_BASE_CYC) * 32'd100;
         4'h3: g = 32'(GATE_BASE_CYC) * 32'd1000;
         default: g = 32'(GATE_BASE_CYC);
      endcase
      return g;
   endfunction

   // Period count for multi-period mode
   function automatic logic [31:0] period_target(input logic [3:0] s);
      logic [31:0] t;
      unique case (s)
         4'h0: t = 32'd1;
         4'h1: t = 32'd10;
         4'h2: t = 32'd100;
         4'h3: t = 32'd1000;
         default: t = 32'd1;
      endcase
      return t;
   endfunction

   // Start and stop edges for the timing modes
   logic start_edge;
   logic stop_edge;
   assign start_edge = (grp == GRP_PERIOD) ? fall
      : (sub == 4'h0 ? fall : rise);
   assign stop_edge = (sub == 4'h0) ? rise : fall;

   // Frequency, multi-period and one-shot sequencer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         meas_q <= M_IDLE;
         cyc_q <= 32'h0000_0000;
         n_q <= 32'h0000_0000;
         done_q <= 1'b0;
         done_val_q <= 32'h0000_0000;
      end else begin
         done_q <= 1'b0;
         if (mode_wr || halt_cmd) begin
            meas_q <= M_IDLE; // Abort on mode change or halt
         end else begin
            unique case (meas_q)
               M_IDLE: begin
                  if (trig && ok && grp == GRP_FREQ) begin
                     meas_q <= M_RUN;
                     cyc_q <= gate_cycles(sub) - 32'd1;
                     n_q <= 32'h0000_0000;
                  end else if (trig && ok && (grp == GRP_PERIOD || grp == GRP_ONESHOT)) begin
                     meas_q <= M_WAIT;
                  end
               end
               M_WAIT: begin
                  if (start_edge) begin
                     meas_q <= M_RUN;
                     cyc_q <= 32'h0000_0000;
                     n_q <= 32'h0000_0000;
                  end
               end
               M_RUN: begin
                  if (grp == GRP_FREQ) begin
                     // Count rising edges until the gate closes
                     n_q <= n_q + {31'h0000_0000, rise};
                     cyc_q <= cyc_q - 32'd1;
                     if (cyc_q == 32'h0000_0000) begin
                        meas_q <= M_IDLE;
                        done_q <= 1'b1;
                        done_val_q <= n_q + {31'h0000_0000, rise};
                     end
                  end else if (grp == GRP_PERIOD) begin
                     // Time until the selected number of falling edges
                     cyc_q <= cyc_q + 32'd1;
                     if (fall) begin
                        n_q <= n_q + 32'd1;
                        if (n_q + 32'd1 == period_target(sub)) begin
                           meas_q <= M_IDLE;
                           done_q <= 1'b1;
                           done_val_q <= cyc_q + 32'd1;
                        end
                     end
                  end else begin
                     // Pulse width until the stop edge
                     cyc_q <= cyc_q + 32'd1;
                     if (stop_edge) begin
                        meas_q <= M_IDLE;
                        done_q <= 1'b1;
                        done_val_q <= cyc_q + 32'd1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Result produced by a trigger or a finished timing measurement, combinational
   logic res_set;
   logic [31:0] res_val;
   logic [1:0] res_err;

   always_comb begin
      res_set = 1'b0;
      res_val = 32'h0000_0000;
      res_err = ERR_NONE;
      if (done_q) begin
         res_set = 1'b1;
         res_val = done_val_q;
      end else if (trig) begin
         if (mode_q == MODE_SKIP) begin
            res_set = 1'b1;
            res_err = ERR_NOT_MEASURED;
         end else if (!ok) begin
            res_set = 1'b1;
            res_err = ERR_UNKNOWN_MODE;
         end else if (mode_q == MODE_STATUS) begin
            res_set = 1'b1;
            res_val = {31'h0000_0000, lvl};
         end else if (grp == GRP_INCR) begin
            res_set = run_q; // Count goes to host only while running
            res_val = 32'(count_q);
         end else if (grp == GRP_TOTAL || grp == GRP_CAPT) begin
            res_set = 1'b1;
            res_val = 32'(count_q);
         end else if (grp == GRP_SWITCH) begin
            res_set = 1'b1;
            res_val = {31'h0000_0000, out_q};
         end
      end
   end

   // Result register; a new result wins over the read that clears valid
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         result_q <= 32'h0000_0000;
         err_q <= ERR_NONE;
         valid_q <= 1'b0;
      end else if (res_set) begin
         result_q <= res_val;
         err_q <= res_err;
         valid_q <= 1'b1;
      end else if (result_rd) begin
         valid_q <= 1'b0;
      end
   end
endmodule

// >>> design/dcc_pkg.sv
// Constants, register map and carrier types for the digital channel counter
package dcc_pkg;

   // Timebase
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned GATE_MIN_MS = 10;
   localparam int unsigned GATE_10MS_CYC = CLK_HZ / 1000 * GATE_MIN_MS;

   // Counter width and wrap
   localparam int unsigned COUNT_W_DEF = 24;

   // Register byte offsets
   localparam logic [11:0] MODE_OFS = 12'h000;
   localparam logic [11:0] CMD_OFS = 12'h004;
   localparam logic [11:0] RESULT_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00C;

   // Command register bits (write one to act)
   localparam int unsigned CMD_TRIG_BIT = 0;
   localparam int unsigned CMD_ZERO_BIT = 1;
   localparam int unsigned CMD_HALT_BIT = 2;
   localparam int unsigned CMD_ARM_BIT = 3;

   // Status register bit positions
   localparam int unsigned ST_VALID_BIT = 0;
   localparam int unsigned ST_ERR_LSB = 1;
   localparam int unsigned ST_LEVEL_BIT = 3;
   localparam int unsigned ST_RUN_BIT = 4;
   localparam int unsigned ST_ARMED_BIT = 5;
   localparam int unsigned ST_OUT_BIT = 6;
   localparam int unsigned ST_OE_BIT = 7;
   localparam int unsigned ST_BUSY_BIT = 8;

   // Error codes
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_NOT_MEASURED = 2'h1;
   localparam logic [1:0] ERR_UNKNOWN_MODE = 2'h2;

   // Mode codes, three digits held as hex nibbles
   localparam logic [11:0] MODE_SKIP = 12'h000;
   localparam logic [11:0] MODE_STATUS = 12'h700;
   localparam logic [7:0] GRP_TOTAL = 8'h74;
   localparam logic [7:0] GRP_INCR = 8'h75;
   localparam logic [7:0] GRP_CAPT = 8'h76;
   localparam logic [7:0] GRP_SWITCH = 8'h80;
   localparam logic [7:0] GRP_FREQ = 8'h90;
   localparam logic [7:0] GRP_PERIOD = 8'h91;
   localparam logic [7:0] GRP_ONESHOT = 8'h92;

   // Reset values
   localparam logic [11:0] MODE_RST = 12'h000;
   localparam logic OUT_RST = 1'b1;

   // Switch pod digital channel range
   localparam int unsigned CHAN_IO_FIRST = 29;
   localparam int unsigned CHAN_IO_LAST = 32;
   localparam int unsigned CHAN_MAX = 32;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage

// >>> design/dcc_in_sync.sv
// Input synchroniser and edge detector for one channel input
`timescale 1ns/100ps
module dcc_in_sync (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic chan_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_q; // First stage, read only by sync_q
   logic sync_q; // Second stage, safe level
   logic last_q; // Previous safe level

   // Two-stage synchroniser plus history flop
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= chan_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // One-cycle edge pulses from synchronised level
   assign level = sync_q;
   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule

// >>> bench/dcc_channel_asserts.sv
// Bus and switch output checks for the digital channel counter
`timescale 1ns/100ps
module dcc_channel_asserts
   import dcc_pkg::*;
#(
   parameter int unsigned CHAN_NUM = 29,
   parameter bit SWITCH_POD = 1'b0
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire dcc_pkg::apb_req_t apb_req,
   input wire dcc_pkg::apb_rsp_t apb_rsp,
   input wire logic chan_out,
   input wire logic chan_oe
);
   // Channel may drive its pin
   localparam bit IO_OK = !SWITCH_POD
      || (CHAN_NUM >= CHAN_IO_FIRST && CHAN_NUM <= CHAN_IO_LAST);
   logic acc; // Access phase
   logic mapped; // Address decodes
   logic mode_wr; // Mode write taken
   logic rd_setup; // Read setup cycle
   assign acc = apb_req.psel && apb_req.penable;
   assign mapped = apb_req.paddr inside {MODE_OFS, CMD_OFS, RESULT_OFS, STATUS_OFS};
   assign mode_wr = acc && apb_req.pwrite && apb_req.paddr == MODE_OFS;
   assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_ready_always: assert property (apb_rsp.pready) else $error("pready low");
   a_err_unmapped: assert property (apb_rsp.pslverr == (acc && !mapped))
      else $error("pslverr wrong");
   a_unmapped_read_zero: assert property (rd_setup && !mapped |=> apb_rsp.prdata == 32'h0)
      else $error("unmapped read not zero");
   a_cmd_read_zero: assert property (rd_setup && apb_req.paddr == CMD_OFS |=> !apb_rsp.prdata)
      else $error("command read not zero");
   a_switch_on: assert property (mode_wr && apb_req.pwdata[11:0] == 12'h801 && IO_OK
      |=> !chan_out && chan_oe) else $error("switch on not driven");
   a_switch_off: assert property (mode_wr && apb_req.pwdata[11:0] == 12'h800 && IO_OK
      |=> chan_out && chan_oe) else $error("switch off not driven");
   a_oe_release: assert property (mode_wr && apb_req.pwdata[11:4] != GRP_SWITCH
      |=> !chan_oe) else $error("pin still driven");
   a_out_cause: assert property ($changed(chan_out) && $past(rstn) |-> $past(mode_wr))
      else $error("output moved without mode write");
   a_status_pins: assert property (rd_setup && apb_req.paddr == STATUS_OFS
      |=> apb_rsp.prdata[ST_OUT_BIT] == $past(chan_out)
      && apb_rsp.prdata[ST_OE_BIT] == $past(chan_oe)) else $error("status pin bits wrong");
   // Main scenarios reached
   c_switch_on: cover property (mode_wr && apb_req.pwdata[11:0] == 12'h801);
   c_unmapped: cover property (acc && !mapped);
   c_status_read: cover property (rd_setup && apb_req.paddr == STATUS_OFS);
endmodule
bind dcc_channel dcc_channel_asserts #(.CHAN_NUM(CHAN_NUM), .SWITCH_POD(SWITCH_POD)) u_chk (
   .core_clk(core_clk),
   .rstn(rstn),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .chan_out(chan_out),
   .chan_oe(chan_oe)
);

// >>> bench/pulse_src.sv
// Field signal source driving the channel input
`timescale 1ns/100ps
module pulse_src (
   input wire logic core_clk,
   output logic chan_in
);
   initial chan_in = 1'b0;
   // Steady level from the next edge on
   task automatic level(input logic v);
      @(posedge core_clk);
      chan_in <= v;
   endtask
   // n pulses: v for a cycles, then the other level for b cycles
   task automatic pulses(input int n, input int a, input int b, input logic v);
      for (int i = 0; i < n; i++) begin
         level(v);
         repeat (a - 1) @(posedge core_clk);
         level(~v);
         repeat (b - 1) @(posedge core_clk);
      end
   endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the digital channel counter
`timescale 1ns/100ps
module tb_top;
   import dcc_pkg::*;
   localparam int unsigned CW = 4; // Short counter so wrap is reached
   typedef struct packed {logic [31:0] d; logic [31:0] m;} exp_t;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   logic chan_in;
   logic chan_out; // Switch output level seen at the pin
   logic chan_oe; // Switch output drive enable seen at the pin
   logic rd_chk = 1'b0; // Current read is compared
   logic [31:0] last_rd; // Data of the last read
   logic [15:0] lfsr_q = 16'hA647; // Seed 42567
   exp_t exp_q[$];
   int fail_count = 0;
   int n_checks = 0;
   always #12.5 core_clk = ~core_clk;
   dcc_channel #(.GATE_BASE_CYC(20), .COUNT_W(CW)) dut (
      .core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe));
   pulse_src src (.core_clk(core_clk), .chan_in(chan_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("Error at %0t: read %h expected %h", $time, seen, want);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Next pseudo-random value in lo .. lo+span-1
   function automatic int rnd(input int lo, input int span);
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lo + int'(lfsr_q) % span;
   endfunction
   // One APB transfer; a read with nonzero mask notes its expectation
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m);
      int n;
      n = 0;
      if (!w && m != 32'h0) exp_q.push_back({d, m});
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: w ? d : 32'h0};
      rd_chk <= !w && m != 32'h0;
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         summarize();
      end
      last_rd = apb_rsp.prdata;
      apb_req <= '0;
      rd_chk <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      xfer(1'b0, a, d, m);
   endtask
   task automatic cmd(input int b);
      wr(CMD_OFS, 32'h1 << b);
   endtask
   task automatic res(input int e);
      rd(RESULT_OFS, 32'(e % (1 << CW)), 32'hFFFFFFFF);
   endtask
   task automatic edges(input int n);
      src.pulses(n, 2, 2, 1'b1);
      repeat (5) @(posedge core_clk);
   endtask
   // Timing mode: set mode, trigger, drive pulses, poll for the result
   task automatic timed(input logic [11:0] md, input int n, input int a, input int b,
                        input logic v, input int e);
      int k;
      k = 0;
      src.level(~v);
      repeat (5) @(posedge core_clk);
      wr(MODE_OFS, {20'h0, md});
      cmd(CMD_TRIG_BIT);
      src.pulses(n, a, b, v);
      do begin
         rd(STATUS_OFS, 32'h0, 32'h0);
         k++;
      end while (last_rd[ST_VALID_BIT] !== 1'b1 && k < 500);
      if (k >= 500) begin
         fail_count++;
         summarize();
      end
      rd(RESULT_OFS, e, 32'hFFFFFFFF);
   endtask
   // Compares each noted read with the oldest expectation
   always @(posedge core_clk) begin : watch
      exp_t e;
      if (rd_chk && apb_req.penable && apb_rsp.pready === 1'b1) begin
         e = exp_q.pop_front();
         check(apb_rsp.prdata & e.m, e.d & e.m);
      end
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      summarize();
   end
   // Main sequence
   initial begin
      int n;
      int h;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(MODE_OFS, MODE_RST, 32'hFFF);
      rd(STATUS_OFS, 32'h40, 32'hC7);
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      cmd(CMD_TRIG_BIT);
      rd(STATUS_OFS, 32'h3, 32'h7);
      res(0);
      wr(MODE_OFS, 32'h123);
      rd(STATUS_OFS, 32'h0, 32'h1);
      cmd(CMD_TRIG_BIT);
      rd(STATUS_OFS, 32'h5, 32'h7);
      for (int k = 0; k < 3; k++) begin
         n = rnd(1, 6);
         src.level(1'b0);
         repeat (4) @(posedge core_clk);
         wr(MODE_OFS, 32'h750 + k);
         cmd(CMD_TRIG_BIT);
         edges(n);
         src.level(1'b1);
         repeat (5) @(posedge core_clk);
         cmd(CMD_TRIG_BIT);
         res(k == 0 ? n : k == 1 ? n + 1 : 2 * n + 1);
         src.pulses(2, 3, 3, 1'b0);
         repeat (5) @(posedge core_clk);
         cmd(CMD_TRIG_BIT);
         res(k == 2 ? 4 : 2);
      end
      src.level(1'b0);
      wr(MODE_OFS, 32'h751);
      cmd(CMD_TRIG_BIT);
      edges(17);
      cmd(CMD_TRIG_BIT);
      res(17);
      wr(MODE_OFS, 32'h741);
      cmd(CMD_TRIG_BIT);
      res(0);
      edges(3);
      cmd(CMD_TRIG_BIT);
      res(3);
      edges(4);
      cmd(CMD_TRIG_BIT);
      res(7);
      cmd(CMD_HALT_BIT);
      edges(2);
      cmd(CMD_TRIG_BIT);
      res(7);
      wr(MODE_OFS, 32'h741);
      cmd(CMD_TRIG_BIT);
      res(0);
      edges(2);
      wr(MODE_OFS, 32'h751);
      edges(3);
      cmd(CMD_TRIG_BIT);
      res(3);
      wr(MODE_OFS, 32'h741);
      cmd(CMD_TRIG_BIT);
      edges(2);
      cmd(CMD_ZERO_BIT);
      edges(3);
      cmd(CMD_TRIG_BIT);
      res(0);
      edges(2);
      cmd(CMD_TRIG_BIT);
      res(2);
      wr(MODE_OFS, 32'h761);
      edges(2);
      cmd(CMD_TRIG_BIT);
      res(0);
      cmd(CMD_ARM_BIT);
      edges(3);
      cmd(CMD_TRIG_BIT);
      res(3);
      wr(MODE_OFS, 32'h801);
      check({30'h0, chan_oe, chan_out}, 32'h2);
      rd(STATUS_OFS, 32'h80, 32'hC0);
      wr(MODE_OFS, 32'h800);
      check({30'h0, chan_oe, chan_out}, 32'h3);
      rd(STATUS_OFS, 32'hC0, 32'hC0);
      wr(MODE_OFS, 32'h700);
      check({30'h0, chan_oe, chan_out}, 32'h1);
      src.level(1'b1);
      repeat (5) @(posedge core_clk);
      cmd(CMD_TRIG_BIT);
      res(1);
      h = rnd(2, 8);
      timed(12'h920, 1, h, 3, 1'b0, h);
      timed(12'h921, 1, h, 3, 1'b1, h);
      timed(12'h910, 2, h, 3, 1'b1, h + 3);
      timed(12'h911, 11, 2, 3, 1'b1, 50);
      timed(12'h901, 10, 2, 2, 1'b1, 10);
      summarize();
   end
endmodule
